/* File: fch_pkg.sv */
/*
  Constants, register map and state types for the flash command host.
  Assumes a 40 MHz clock and a byte-wide flash with a 21-bit address.
*/
package fch_pkg;

  // ---------------------------------------------------------------
  // Clock and pin timing
  // ---------------------------------------------------------------
  localparam int FCH_CLK_MHZ      = 40;
  localparam int FCH_RST_LOW_NS   = 100;
  localparam int FCH_WAKE_WR_NS   = 1000;
  localparam int FCH_WAKE_RD_NS   = 1000;
  localparam int FCH_WE_LOW_NS    = 50;
  localparam int FCH_ACCESS_NS    = 150;

  // Least times, rounded up to whole cycles
  localparam logic [7:0] FCH_RST_LOW_CYC = 8'((FCH_RST_LOW_NS * FCH_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FCH_WAKE_WR_CYC = 8'((FCH_WAKE_WR_NS * FCH_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FCH_WAKE_RD_CYC = 8'((FCH_WAKE_RD_NS * FCH_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FCH_WE_LOW_CYC  = 8'((FCH_WE_LOW_NS * FCH_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FCH_ACCESS_CYC  = 8'((FCH_ACCESS_NS * FCH_CLK_MHZ + 999) / 1000);

  // ---------------------------------------------------------------
  // Register map (byte offsets on APB)
  // ---------------------------------------------------------------
  localparam logic [11:0] FCH_OFS_CTRL   = 12'h000;
  localparam logic [11:0] FCH_OFS_ADDR   = 12'h004;
  localparam logic [11:0] FCH_OFS_DATA   = 12'h008;
  localparam logic [11:0] FCH_OFS_STATUS = 12'h00c;

  localparam int FCH_CTRL_OP_LSB   = 0;
  localparam int FCH_CTRL_START    = 3;
  localparam int FCH_CTRL_OVRD     = 8;
  localparam int FCH_DATA_SEC_LSB  = 8;
  localparam int FCH_STAT_RD_LSB   = 8;

  // ---------------------------------------------------------------
  // Operations and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_CMD1  = 3'b001,
    OP_CMD2  = 3'b010,
    OP_READ  = 3'b011,
    OP_RESET = 3'b100
  } fch_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARM   = 3'b001,
    ST_WSET  = 3'b010,
    ST_WLOW  = 3'b011,
    ST_WRISE = 3'b100,
    ST_WEND  = 3'b101,
    ST_RACC  = 3'b110,
    ST_RPLOW = 3'b111
  } fch_state_t;

  typedef struct packed {
    fch_state_t  state;
    logic [7:0]  cnt;
    logic [7:0]  wakeWrCnt;
    logic [7:0]  wakeRdCnt;
    logic        secondDue;
    logic [2:0]  op;
    logic        override;
    logic [20:0] addr;
    logic [7:0]  cmdByte;
    logic [7:0]  secondByte;
    logic [7:0]  readData;
    logic        readyBusySeen;
    logic [20:0] flashAddr;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic        chipSelectN;
    logic        outputEnableN;
    logic        writeStrobeN;
    logic        resetPowerdownN;
    logic        lockOverride;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fch_regs_t;

  // Reset holds the flash in power-down for the least low time
  localparam fch_regs_t FCH_REGS_RST = '{
    state: ST_RPLOW, cnt: FCH_RST_LOW_CYC, wakeWrCnt: 8'h00, wakeRdCnt: 8'h00,
    secondDue: 1'b0, op: 3'h0, override: 1'b0, addr: 21'h000000,
    cmdByte: 8'h00, secondByte: 8'h00, readData: 8'h00, readyBusySeen: 1'b0,
    flashAddr: 21'h000000, dataOut: 8'h00, dataOe: 1'b0, chipSelectN: 1'b1,
    outputEnableN: 1'b1, writeStrobeN: 1'b1, resetPowerdownN: 1'b0,
    lockOverride: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};

endpackage

/* File: fch_host.sv */
/*
  Host-side controller for a byte-wide asynchronous flash command port.
  Software posts an operation over APB; the controller plays the chip
  select, write strobe, output enable and reset/power-down pins.
  Assumes flash inputs are synchronous to clk and one APB master.
  Assumes software starts one operation at a time and polls STATUS
  busy before the next; a start while busy is dropped silently.
  The reset/power-down pin is pulsed after every sys_rst as well,
  so the flash always wakes in its read-array mode.
*/
// Implementation choices: the register offsets and register access over APB.
// Behaviour
// - Hold reset_powerdown_n low at least 100 ns
// - Wait wake times before writes and reads
// - System reset also drives reset_powerdown_n
// - Never output enable and write strobe together
// - Erase is 20H then D0H, same block
`timescale 1ns/1ps

module fch_host
  import fch_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  output logic      [20:0] flashAddr,
  output logic      [7:0]  dataLinesOut,
  output logic             dataLinesOe,
  input  wire logic [7:0]  dataLinesIn,
  output logic             chipSelectN,
  output logic             outputEnableN,
  output logic             writeStrobeN,
  output logic             resetPowerdownN,
  output logic             lockOverride,
  input  wire logic        readyBusy
);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  function automatic logic [1:0] fchRegIdx(input logic [11:0] a);
    unique case (a)
      FCH_OFS_CTRL:   fchRegIdx = 2'd0;
      FCH_OFS_ADDR:   fchRegIdx = 2'd1;
      FCH_OFS_DATA:   fchRegIdx = 2'd2;
      default:        fchRegIdx = 2'd3;
    endcase
  endfunction

  // Any other offset answers with an error
  function automatic logic fchRegHit(input logic [11:0] a);
    fchRegHit = (a == FCH_OFS_CTRL) || (a == FCH_OFS_ADDR) ||
                (a == FCH_OFS_DATA) || (a == FCH_OFS_STATUS);
  endfunction

  fch_regs_t r;
  fch_regs_t next_r;

  logic [31:0] readMux;
  logic        busy;

  assign busy = (r.state != ST_IDLE);

  always_comb begin
    readMux = 32'h00000000;
    unique case (fchRegIdx(paddr))
      2'd0: begin
        readMux[FCH_CTRL_OP_LSB +: 3] = r.op;
        readMux[FCH_CTRL_OVRD]        = r.override;
      end
      2'd1: readMux[20:0] = r.addr;
      2'd2: readMux[15:0] = {r.secondByte, r.cmdByte};
      2'd3: begin
        readMux[0] = busy;
        readMux[1] = r.readyBusySeen;
        readMux[2] = (r.wakeWrCnt != 8'h00);
        readMux[3] = (r.wakeRdCnt != 8'h00);
        readMux[FCH_STAT_RD_LSB +: 8] = r.readData;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.readyBusySeen = readyBusy;

    // -------------------------------------------------------------
    // Wake timers
    // -------------------------------------------------------------
    if (r.wakeWrCnt != 8'h00) begin
      next_r.wakeWrCnt = r.wakeWrCnt - 8'h01;
    end
    if (r.wakeRdCnt != 8'h00) begin
      next_r.wakeRdCnt = r.wakeRdCnt - 8'h01;
    end

    // -------------------------------------------------------------
    // Flash pin sequencer
    // -------------------------------------------------------------
    unique case (r.state)
      ST_IDLE: begin
        // Pins rest high between operations
        next_r.chipSelectN   = 1'b1;
        next_r.outputEnableN = 1'b1;
        next_r.writeStrobeN  = 1'b1;
        next_r.dataOe        = 1'b0;
      end
      ST_ARM: begin
        // Wait here until the flash has woken
        if (r.op == OP_READ) begin
          if (r.wakeRdCnt == 8'h00) begin
            next_r.state         = ST_RACC;
            next_r.cnt           = FCH_ACCESS_CYC;
            next_r.flashAddr     = r.addr;
            next_r.chipSelectN   = 1'b0;
            next_r.outputEnableN = 1'b0;
          end
        end else if (r.wakeWrCnt == 8'h00) begin
          next_r.state       = ST_WSET;
          next_r.flashAddr   = r.addr;
          next_r.dataOut     = r.cmdByte;
          next_r.dataOe      = 1'b1;
          next_r.chipSelectN = 1'b0;
          next_r.secondDue   = (r.op == OP_CMD2);
        end
      end
      ST_WSET: begin
        // Address and data settle a cycle before the strobe
        next_r.state        = ST_WLOW;
        next_r.cnt          = FCH_WE_LOW_CYC;
        next_r.writeStrobeN = 1'b0;
      end
      ST_WLOW: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.state        = ST_WRISE;
          next_r.writeStrobeN = 1'b1;
        end
      end
      ST_WRISE: begin
        next_r.state       = ST_WEND;
        next_r.chipSelectN = 1'b1;
      end
      ST_WEND: begin
        if (r.secondDue) begin
          // Second cycle keeps the same address
          next_r.state       = ST_WSET;
          next_r.dataOut     = r.secondByte;
          next_r.chipSelectN = 1'b0;
          next_r.secondDue   = 1'b0;
        end else begin
          next_r.state  = ST_IDLE;
          next_r.dataOe = 1'b0;
        end
      end
      ST_RACC: begin
        // Data are taken on the last access cycle
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.state         = ST_IDLE;
          next_r.readData      = dataLinesIn;
          next_r.chipSelectN   = 1'b1;
          next_r.outputEnableN = 1'b1;
        end
      end
      ST_RPLOW: begin
        next_r.resetPowerdownN = 1'b0;
        next_r.cnt             = r.cnt - 8'h01;
        // Wake timers start as the pin rises
        if (r.cnt <= 8'h01) begin
          next_r.state           = ST_IDLE;
          next_r.resetPowerdownN = 1'b1;
          next_r.wakeWrCnt       = FCH_WAKE_WR_CYC;
          next_r.wakeRdCnt       = FCH_WAKE_RD_CYC;
        end
      end
    endcase

    // -------------------------------------------------------------
    // APB slave: answer one cycle into the access phase
    // -------------------------------------------------------------
    if (r.pready) begin
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;
      if (psel && penable && pwrite && fchRegHit(paddr)) begin
        unique case (fchRegIdx(paddr))
          2'd0: begin
            next_r.op           = pwdata[FCH_CTRL_OP_LSB +: 3];
            next_r.override     = pwdata[FCH_CTRL_OVRD];
            // Override level must not move under a running operation
            if (!busy) begin
              next_r.lockOverride = pwdata[FCH_CTRL_OVRD];
            end
            if (pwdata[FCH_CTRL_START] && !busy) begin
              unique case (pwdata[FCH_CTRL_OP_LSB +: 3])
                OP_CMD1, OP_CMD2, OP_READ: begin
                  next_r.state = ST_ARM;
                end
                OP_RESET: begin
                  next_r.state           = ST_RPLOW;
                  next_r.cnt             = FCH_RST_LOW_CYC;
                  next_r.resetPowerdownN = 1'b0;
                  next_r.chipSelectN     = 1'b1;
                  next_r.outputEnableN   = 1'b1;
                  next_r.writeStrobeN    = 1'b1;
                  next_r.dataOe          = 1'b0;
                end
                default: begin
                  next_r.state = r.state;
                end
              endcase
            end
          end
          2'd1: next_r.addr = pwdata[20:0];
          2'd2: begin
            next_r.cmdByte    = pwdata[7:0];
            next_r.secondByte = pwdata[FCH_DATA_SEC_LSB +: 8];
          end
          2'd3: begin
            // STATUS is read-only; writes are dropped
            next_r.pslverr = 1'b0;
          end
        endcase
      end
    end else if (psel && penable) begin
      next_r.pready  = 1'b1;
      next_r.pslverr = !fchRegHit(paddr);
      next_r.prdata  = (!pwrite && fchRegHit(paddr)) ? readMux : 32'h00000000;
    end

    // -------------------------------------------------------------
    // Pin safety
    // -------------------------------------------------------------
    // Flash stays deselected while its reset pin is low
    if (!next_r.resetPowerdownN) begin
      next_r.chipSelectN   = 1'b1;
      next_r.outputEnableN = 1'b1;
      next_r.writeStrobeN  = 1'b1;
    end
    // No write strobe or data drive while the flash may drive the bus
    if (!next_r.outputEnableN) begin
      next_r.writeStrobeN = 1'b1;
      next_r.dataOe       = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= FCH_REGS_RST;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign flashAddr       = r.flashAddr;
  assign dataLinesOut    = r.dataOut;
  assign dataLinesOe     = r.dataOe;
  assign chipSelectN     = r.chipSelectN;
  assign outputEnableN   = r.outputEnableN;
  assign writeStrobeN    = r.writeStrobeN;
  assign resetPowerdownN = r.resetPowerdownN;
  assign lockOverride    = r.lockOverride;

endmodule

/* File: fch_host_chk_sva.sv */
/*
  Checker of the flash pins and the APB answer of fch_host.
  Assumes it is bound to fch_host and sees only its ports.
*/
`timescale 1ns/1ps
module fch_host_chk
  import fch_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [20:0] flashAddr,
  input wire logic        dataLinesOe,
  input wire logic        chipSelectN,
  input wire logic        outputEnableN,
  input wire logic        writeStrobeN,
  input wire logic        resetPowerdownN
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] wakeCnt;
  // ---------------------------------------------------------------
  // Cycles since the flash left power-down
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || !resetPowerdownN) wakeCnt <= 8'h00;
    else if (wakeCnt != 8'hff) wakeCnt <= wakeCnt + 8'h01;
  end
  sequence sPdHold;
    !resetPowerdownN [*4];
  endsequence
  sequence sWrLow;
    !chipSelectN && !writeStrobeN;
  endsequence
  AST_PD_HOLD: assert property ($fell(resetPowerdownN) |-> sPdHold)
    else $error("power-down pulse short");
  AST_SYS_PD: assert property ($fell(sys_rst) |-> sPdHold)
    else $error("system reset not passed to flash");
  AST_WAKE_WR: assert property (!writeStrobeN |-> wakeCnt >= FCH_WAKE_WR_CYC)
    else $error("write inside wake time");
  AST_WAKE_RD: assert property ($fell(outputEnableN) |-> wakeCnt >= FCH_WAKE_RD_CYC)
    else $error("read inside wake time");
  AST_NO_OE_WE: assert property (outputEnableN || writeStrobeN)
    else $error("output enable and write strobe both low");
  AST_WR_FRAME: assert property ($fell(writeStrobeN) |-> sWrLow ##1 sWrLow
    ##1 (writeStrobeN && !chipSelectN)) else $error("strobe not inside chip select");
  AST_ADDR_HOLD: assert property (!chipSelectN && !$past(chipSelectN) |-> $stable(flashAddr))
    else $error("address moved during access");
  AST_APB_ANS: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle into access");
  AST_WR_DRIVE: assert property (!writeStrobeN |-> dataLinesOe)
    else $error("write strobe without data drive");
  AST_RD_FLOAT: assert property (!outputEnableN |-> !dataLinesOe)
    else $error("data driven during read");
endmodule

/* File: fch_flash_model.sv */
/*
  Behavioural flash command port for the host bench.
  Assumes pins change on clk edges, as the host drives them.
*/
`timescale 1ns/1ps
module fch_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h3c  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic [20:0] flashAddr,
  input  wire logic [7:0]  dataLinesOut,
  input  wire logic        chipSelectN,
  input  wire logic        outputEnableN,
  input  wire logic        writeStrobeN,
  input  wire logic        resetPowerdownN,
  input  wire logic        lockOverride,
  output logic      [7:0]  dataLinesIn,
  output logic             readyBusy
);
  logic [31:0] locks = '0;
  logic [7:0]  mode, first, status, rdByte, lastOut = 8'h00;
  logic        master = 1'b0, wasWr, susp;
  int          busyCnt = 0;
  wire logic   drv = !chipSelectN && !outputEnableN && resetPowerdownN;
  wire logic [7:0] d = dataLinesOut;
  assign readyBusy = busyCnt == 0 || susp || !resetPowerdownN;
  // Released bus shows the inverse of the last byte
  assign dataLinesIn = drv ? rdByte : ~lastOut;
  always_comb begin
    case (mode)
      8'hff: rdByte = flashAddr[7:0] ^ 8'ha5;
      8'h90: case (flashAddr[1:0])
        2'd0: rdByte = MAKER_ID;
        2'd1: rdByte = PART_ID;
        2'd2: rdByte = {7'h00, locks[flashAddr[20:16]]};
        default: rdByte = {7'h00, master};
      endcase
      default: rdByte = {busyCnt == 0 || susp, susp, status[5:0]};
    endcase
  end
  always @(posedge clk) begin
    wasWr <= !chipSelectN && !writeStrobeN;
    if (drv) lastOut <= rdByte;
    if (!resetPowerdownN) begin
      mode <= 8'hff;
      first <= 8'h00;
      status <= 8'h00;
      busyCnt <= 0;
      susp <= 1'b0;
    end else begin
      if (busyCnt != 0 && !susp) busyCnt <= busyCnt - 1;
      if (wasWr && (chipSelectN || writeStrobeN)) begin
        first <= 8'h00;
        if (first != 8'h00) mode <= 8'h70;
        if (first == 8'h60) begin
          if (d == 8'h01 && (!master || lockOverride)) locks[flashAddr[20:16]] <= 1'b1;
          if (d == 8'hf1 && lockOverride) master <= 1'b1;
          if (d == 8'hd0 && (!master || lockOverride)) locks <= '0;
        end else if (first == 8'h20 && d != 8'hd0) status <= status | 8'h30;
        else if (first != 8'h00 && locks[flashAddr[20:16]] && !lockOverride)
          status <= status | (first == 8'h20 ? 8'h22 : 8'h12);
        else if (first != 8'h00) busyCnt <= 400;
        else case (d)
          8'hff: if (busyCnt == 0 || susp) mode <= d;
          8'h90, 8'h70: mode <= d;
          8'h50: status <= 8'h00;
          8'hb0, 8'hd0: begin
            susp <= d == 8'hb0 && busyCnt != 0;
            mode <= 8'h70;
          end
          default: first <= d;
        endcase
      end
    end
  end
endmodule

/* File: fch_host_tb.sv */
/*
  Self-checking bench: fch_host driving a behavioural flash.
  Assumes the host's APB register layout and timing from its hand-over.
*/
`timescale 1ns/1ps
module fch_host_tb
  import fch_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART  = 8'h3c; // Arbitrary value
  logic        clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ov = 1'b0, err, pready, pslverr, dataLinesOe, readyBusy;
  logic        chipSelectN, outputEnableN, writeStrobeN, resetPowerdownN, lockOverride;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [20:0] flashAddr, a = 21'h0;
  logic [7:0]  dataLinesOut, dataLinesIn;
  int          nFail = 0, nCompared = 0;

  always #12.5 clk = ~clk;

  fch_host i_fch_host (.clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .flashAddr, .dataLinesOut, .dataLinesOe, .dataLinesIn,
    .chipSelectN, .outputEnableN, .writeStrobeN, .resetPowerdownN, .lockOverride, .readyBusy);
  fch_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) i_fch_flash_model (.clk, .flashAddr,
    .dataLinesOut, .chipSelectN, .outputEnableN, .writeStrobeN, .resetPowerdownN,
    .lockOverride, .dataLinesIn, .readyBusy);

  task automatic testDone();
    $display("compared %0d failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    nCompared++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      nFail++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wrData);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wrData;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Post one flash operation at address a, then poll until done
  task automatic fop(input logic [2:0] op, input logic [15:0] d);
    int t;
    apb(1'b1, FCH_OFS_ADDR, {11'h0, a});
    apb(1'b1, FCH_OFS_DATA, {16'h0, d});
    apb(1'b1, FCH_OFS_CTRL, {23'h0, ov, 4'h0, 1'b1, op});
    t = 0;
    do begin
      apb(1'b0, FCH_OFS_STATUS, 32'h0);
      t++;
    end while (r[0] !== 1'b0 && t < 100);
    if (r[0] !== 1'b0) begin
      $display("BAD busy expected 0 seen %b", r[0]);
      nFail++;
      testDone();
    end
  endtask
  task automatic rd(input string n, input logic [7:0] e);
    fop(3'd3, 16'h0000);
    chk(n, e, r[15:8]);
  endtask
  function automatic logic [7:0] expArr(input logic [20:0] ad);
    return ad[7:0] ^ 8'ha5;
  endfunction

  initial begin
    #(25 * 20000);
    nFail++;
    testDone();
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    void'($urandom(32'hf7f12584));
    for (int i = 0; i < 3; i++) begin
      a = 21'($urandom);
      rd("array", expArr(a));
    end
    // Clock enable low freezes a read in flight
    apb(1'b1, FCH_OFS_CTRL, {23'h0, ov, 4'h0, 1'b1, 3'd3});
    clkEn <= 1'b0;
    repeat (20) @(posedge clk);
    chk("freezeCs", 8'h00, {7'h0, chipSelectN});
    clkEn <= 1'b1;
    rd("freezeRead", expArr(a));
    fop(3'd1, 16'h0090);
    for (int i = 0; i < 4; i++) begin
      a[1:0] = 2'(i);
      rd("ident", i == 0 ? MAKER : i == 1 ? PART : 8'h00);
    end
    fop(3'd2, 16'hff20);
    rd("badErase", 8'hb0);
    fop(3'd1, 16'h0050);
    rd("clear", 8'h80);
    fop(3'd2, 16'h0160);
    fop(3'd2, 16'hd020);
    rd("lockedErase", 8'ha2);
    fop(3'd1, 16'h0050);
    ov = 1'b1;
    fop(3'd2, 16'hd020);
    ov = 1'b0;
    rd("eraseBusy", 8'h00);
    fop(3'd1, 16'h00b0);
    chk("suspReady", 8'h01, {7'h0, r[1]});
    rd("suspStat", 8'hc0);
    fop(3'd1, 16'h00d0);
    chk("resumeBusy", 8'h00, {7'h0, r[1]});
    fop(3'd1, 16'h00ff);
    rd("arrayIgnored", 8'h00);
    fop(3'd4, 16'h0000);
    chk("abortReady", 8'h01, {7'h0, r[1]});
    rd("abortArray", expArr(a));
    fop(3'd1, 16'h0070);
    rd("wakeStat", 8'h80);
    for (int k = 0; k < 2; k++) begin
      ov = k[0];
      fop(3'd2, 16'hf160);
      ov = 1'b0;
      fop(3'd1, 16'h0090);
      a[1:0] = 2'd3;
      rd("master", 8'(k));
    end
    for (int k = 0; k < 2; k++) begin
      ov = k[0];
      fop(3'd2, 16'hd060);
      ov = 1'b0;
      fop(3'd1, 16'h0090);
      a[1:0] = 2'd2;
      rd("blockLock", 8'(1 - k));
    end
    for (int k = 0; k < 2; k++) begin
      fop(3'd2, {8'h55, k == 0 ? 8'h40 : 8'h10});
      rd("program", 8'h00);
      fop(3'd4, 16'h0000);
    end
    apb(1'b0, 12'hff0, 32'h0);
    chk("unmapped", 8'h01, {7'h0, err});
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    a = 21'($urandom);
    rd("sysReset", expArr(a));
    testDone();
  end
endmodule

bind fch_host fch_host_chk i_fch_host_chk (.clk, .sys_rst, .psel, .penable, .pready,
  .flashAddr, .dataLinesOe, .chipSelectN, .outputEnableN, .writeStrobeN, .resetPowerdownN);
